// ---- bench/bdc_status_control_properties.sv ----
// port assertions for the debug status and control block
`timescale 1ns/1ps
module background_debug_status_control_check (
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic [2:0]  CMD,
    input wire logic        CMD_STROBE,
    input wire logic [15:0] CMD_DATA,
    input wire logic [15:0] RESP_DATA,
    input wire logic        RESP_VALID,
    input wire logic        CMD_REFUSED,
    input wire logic        CPU_QUEUE_END,
    input wire logic        CPU_TAG_OUT,
    input wire logic        CPU_FLUSH,
    input wire logic        CPU_RESUME,
    input wire logic        ENTER_BACKGROUND,
    input wire logic        SWI_INSTEAD,
    input wire logic        BACKGROUND_ACTIVE,
    input wire logic        COMM_CLOCK_SELECT
);
    // ----
    // one domain, so one clock and one reset for all
    // ----
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    read_answer_a: assert property (
        CMD_STROBE && CMD == bdc_pkg::CMD_READ_STAT |=> RESP_VALID && !CMD_REFUSED
        && RESP_DATA[15:8] == 8'h00 && !RESP_DATA[0]) else $error("status read unanswered");
    status_mirror_a: assert property (
        CMD_STROBE && CMD == bdc_pkg::CMD_READ_STAT |=> RESP_DATA[6] == $past(BACKGROUND_ACTIVE)
        && RESP_DATA[3] == $past(COMM_CLOCK_SELECT)) else $error("status byte stale");
    clock_select_a: assert property (
        CMD_STROBE && CMD == bdc_pkg::CMD_WRITE_CTRL |=> CMD_REFUSED
        || COMM_CLOCK_SELECT == $past(CMD_DATA[3])) else $error("clock select not written");
    ctrl_keeps_active_a: assert property (
        CMD_STROBE && CMD == bdc_pkg::CMD_WRITE_CTRL && !CPU_RESUME && !ENTER_BACKGROUND
        |=> $stable(BACKGROUND_ACTIVE)) else $error("write moved active bit");
    enter_once_a: assert property (
        ENTER_BACKGROUND |-> !SWI_INSTEAD ##1 BACKGROUND_ACTIVE) else $error("entry not taken");
    active_holds_a: assert property (
        BACKGROUND_ACTIVE && !CPU_RESUME |=> BACKGROUND_ACTIVE) else $error("active bit dropped");
    resume_clears_a: assert property (
        BACKGROUND_ACTIVE && CPU_RESUME |=> !BACKGROUND_ACTIVE) else $error("active after resume");
    tag_enter_a: assert property (
        CPU_QUEUE_END && CPU_TAG_OUT && !CPU_FLUSH && !BACKGROUND_ACTIVE
        |-> ENTER_BACKGROUND || SWI_INSTEAD) else $error("tagged opcode executed");
endmodule
bind background_debug_status_control background_debug_status_control_check chk_u (
    .MCLK(MCLK), .RST_N(RST_N), .CMD(CMD), .CMD_STROBE(CMD_STROBE),
    .CMD_DATA(CMD_DATA), .RESP_DATA(RESP_DATA), .RESP_VALID(RESP_VALID),
    .CMD_REFUSED(CMD_REFUSED), .CPU_QUEUE_END(CPU_QUEUE_END), .CPU_TAG_OUT(CPU_TAG_OUT),
    .CPU_FLUSH(CPU_FLUSH), .CPU_RESUME(CPU_RESUME), .ENTER_BACKGROUND(ENTER_BACKGROUND),
    .SWI_INSTEAD(SWI_INSTEAD), .BACKGROUND_ACTIVE(BACKGROUND_ACTIVE),
    .COMM_CLOCK_SELECT(COMM_CLOCK_SELECT));

// ---- bench/bdc_status_control_tb.sv ----
// self-checking bench for the debug status and control block
`timescale 1ns/1ps
module background_debug_status_control_tb;
    typedef struct packed {logic [7:0] wr; logic [7:0] st;} row_type;
    logic        MCLK;
    logic        RST_N;
    logic [2:0]  cmd;
    logic        strobe;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rvalid;
    logic        CMD_REFUSED;
    logic [15:0] addr;
    logic [7:0]  cpu_in;
    logic        TAG_IN;
    logic        ENTER_BACKGROUND;
    logic        SWI_INSTEAD;
    logic        BACKGROUND_ACTIVE;
    logic        WAKE_FROM_WAIT;
    logic        COMM_CLOCK_SELECT;
    logic [15:0] d;
    int          err_total = 0;
    int          n_tests = 0;
    row_type     rows [5] = '{'{8'h00, 8'h00}, '{8'h08, 8'h08}, '{8'h30, 8'h30},
                              '{8'h47, 8'h00}, '{8'hFF, 8'hB8}};
    background_debug_status_control dut_u (.MCLK(MCLK), .RST_N(RST_N), .CMD(cmd),
        .CMD_STROBE(strobe), .CMD_DATA(wdata), .RESP_DATA(rdata), .RESP_VALID(rvalid),
        .CMD_REFUSED(CMD_REFUSED),
        .CPU_ADDR(addr), .CPU_FETCH(cpu_in[7]), .CPU_BOUNDARY(cpu_in[6]),
        .CPU_QUEUE_END(cpu_in[5]), .CPU_TAG_OUT(cpu_in[4]), .CPU_FLUSH(cpu_in[3]),
        .CPU_WAIT_STOP_ENTER(cpu_in[2]), .CPU_BGND_OP(cpu_in[1]), .CPU_RESUME(cpu_in[0]),
        .TAG_IN(TAG_IN), .ENTER_BACKGROUND(ENTER_BACKGROUND), .SWI_INSTEAD(SWI_INSTEAD),
        .BACKGROUND_ACTIVE(BACKGROUND_ACTIVE), .WAKE_FROM_WAIT(WAKE_FROM_WAIT),
        .COMM_CLOCK_SELECT(COMM_CLOCK_SELECT));
    debug_host host_u (.MCLK(MCLK), .cmd(cmd), .strobe(strobe), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));
    // ----
    // clock, checks and verdict
    // ----
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // cpu pulse for one cycle; comb outputs looked at inside that cycle
    task automatic pulse(input logic [7:0] v, input logic [3:0] e);
        @(negedge MCLK);
        cpu_in = v;
        #1 chk({12'h000, TAG_IN, ENTER_BACKGROUND, SWI_INSTEAD, WAKE_FROM_WAIT}, {12'h000, e});
        @(negedge MCLK);
        cpu_in = 8'h00;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a hang costs far more than the ~100 cycles the tests need
    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
    // ----
    // main sequence
    // ----
    initial begin
        RST_N = 1'b0;
        cpu_in = 8'h00;
        addr = 16'hFFFF;
        repeat (10) @(posedge MCLK);
        @(negedge MCLK) RST_N = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host_u.send(bdc_pkg::CMD_WRITE_CTRL, {8'h00, rows[i].wr});
            host_u.read(bdc_pkg::CMD_READ_STAT, d);
            chk(d, {8'h00, rows[i].st});
            chk({15'h0000, COMM_CLOCK_SELECT}, {15'h0000, rows[i].st[3]});
        end
        host_u.send(bdc_pkg::CMD_WRITE_BRK, 16'hA5C3);
        host_u.read(bdc_pkg::CMD_READ_BRK, d);
        chk(d, 16'hA5C3);
        addr = 16'hA5C3;
        pulse(8'h40, 4'b0100);
        addr = 16'hFFFF;
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h00F8);
        host_u.send(bdc_pkg::CMD_WRITE_CTRL, 16'h0028);
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h00E8);
        pulse(8'h01, 4'b0000);
        chk({15'h0000, BACKGROUND_ACTIVE}, 16'h0000);
        addr = 16'hA5C3;
        pulse(8'h80, 4'b1000);
        addr = 16'hFFFF;
        pulse(8'h38, 4'b0000);
        pulse(8'h30, 4'b0100);
        pulse(8'h01, 4'b0000);
        pulse(8'h02, 4'b0100);
        pulse(8'h01, 4'b0000);
        host_u.send(bdc_pkg::CMD_WRITE_CTRL, 16'h0098);
        addr = 16'hA5C3;
        pulse(8'hC0, 4'b0000);
        addr = 16'hFFFF;
        pulse(8'h04, 4'b0000);
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h009C);
        host_u.send(bdc_pkg::CMD_WRITE_BRK, 16'h1234);
        chk({15'h0000, CMD_REFUSED}, 16'h0001);
        fork
            host_u.bgnd(d);
            begin
                @(negedge MCLK);
                #1 chk({15'h0000, WAKE_FROM_WAIT}, 16'h0001);
            end
        join
        chk(d, 16'h00DC);
        pulse(8'h01, 4'b0000);
        fork
            host_u.send(bdc_pkg::CMD_MEMORY, 16'h0000);
            pulse(8'h04, 4'b0000);
        join
        host_u.bgnd(d);
        chk(d, 16'h00DE);
        host_u.send(bdc_pkg::CMD_MEMORY, 16'h0000);
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h00DC);
        pulse(8'h01, 4'b0000);
        @(negedge MCLK) RST_N = 1'b0;
        @(negedge MCLK) RST_N = 1'b1;
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h0000);
        host_u.send(bdc_pkg::CMD_WRITE_CTRL, 16'h0030);
        addr = 16'h0000;
        pulse(8'h40, 4'b0010);
        host_u.send(bdc_pkg::CMD_BACKGROUND, 16'h0000);
        host_u.read(bdc_pkg::CMD_READ_STAT, d);
        chk(d, 16'h0030);
        print_verdict();
    end
endmodule

// ---- bench/debug_host.sv ----
// debug host model issuing serial commands to the block
`timescale 1ns/1ps
module debug_host (
    input  wire logic        MCLK,
    output logic [2:0]       cmd,
    output logic             strobe,
    output logic [15:0]      wdata,
    input  wire logic [15:0] rdata,
    input  wire logic        rvalid
);
    initial begin
        cmd = bdc_pkg::CMD_NONE;
        strobe = 1'b0;
        wdata = 16'h0000;
    end
    // one command a call; idle data is inverted so nothing leans on a stale value
    task automatic send(input logic [2:0] c, input logic [15:0] d);
        @(negedge MCLK);
        cmd = c;
        wdata = d;
        strobe = 1'b1;
        @(negedge MCLK);
        strobe = 1'b0;
        cmd = bdc_pkg::CMD_NONE;
        wdata = ~d;
    endtask
    // the answer stands only in the cycle after the taking edge
    task automatic read(input logic [2:0] c, output logic [15:0] d);
        send(c, 16'h0000);
        d = rvalid ? rdata : 16'hXXXX;
    endtask
    // after forcing background, status is read before anything else
    task automatic bgnd(output logic [15:0] d);
        send(bdc_pkg::CMD_BACKGROUND, 16'h0000);
        read(bdc_pkg::CMD_READ_STAT, d);
    endtask
endmodule

// ---- hdl/bdc_pkg.sv ----
// package of constants for the background debug status and control block
package bdc_pkg;
    // debug_status_control field positions
    localparam int BIT_PERMIT      = 7;
    localparam int BIT_ACTIVE      = 6;
    localparam int BIT_BRK_EN      = 5;
    localparam int BIT_FORCE_TAG   = 4;
    localparam int BIT_CLK_SEL     = 3;
    localparam int BIT_WAIT_STOP   = 2;
    localparam int BIT_WS_FAIL     = 1;
    localparam int BIT_DV_FAIL     = 0;
    // reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] MATCH_RESET = 16'h0000;
    // serial command codes seen by this block
    localparam logic [2:0] CMD_NONE       = 3'h0;
    localparam logic [2:0] CMD_READ_STAT  = 3'h1;
    localparam logic [2:0] CMD_WRITE_CTRL = 3'h2;
    localparam logic [2:0] CMD_READ_BRK   = 3'h3;
    localparam logic [2:0] CMD_WRITE_BRK  = 3'h4;
    localparam logic [2:0] CMD_BACKGROUND = 3'h5;
    localparam logic [2:0] CMD_MEMORY     = 3'h6;
    localparam logic [2:0] CMD_OTHER      = 3'h7;
    // processor run state, one-hot
    typedef enum logic [2:0] {
        RUN_USER   = 3'b001,
        RUN_ACTIVE = 3'b010,
        RUN_WAIT   = 3'b100
    } run_type;
endpackage

// ---- hdl/bdc_status_control.sv ----
// status/control and breakpoint register of the background debug controller
//
// Operation
// - registers reached only through serial commands
// - permit bit write ignored while active
// - status bits never changed by writes
// - clock select free, reset zero alternate
// - permit zero blocks background entry
// - active bit mirrors background state
// - breakpoint off ignores select and match
// - force match enters at instruction boundary
// - tag match enters when opcode executes
// - wait stop bit tracks wait entry
// - wait blocks commands except background and status read
// - failure bit set on wait collision
// - data valid failure never reported
// - breakpoint register sixteen bits via commands
`timescale 1ns/1ps
module background_debug_status_control (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [2:0]  CMD,
    input  wire logic        CMD_STROBE,
    input  wire logic [15:0] CMD_DATA,
    output logic [15:0]      RESP_DATA,
    output logic             RESP_VALID,
    output logic             CMD_REFUSED,
    input  wire logic [15:0] CPU_ADDR,
    input  wire logic        CPU_FETCH,
    input  wire logic        CPU_BOUNDARY,
    input  wire logic        CPU_QUEUE_END,
    input  wire logic        CPU_TAG_OUT,
    input  wire logic        CPU_FLUSH,
    input  wire logic        CPU_WAIT_STOP_ENTER,
    input  wire logic        CPU_BGND_OP,
    input  wire logic        CPU_RESUME,
    output logic             TAG_IN,
    output logic             ENTER_BACKGROUND,
    output logic             SWI_INSTEAD,
    output logic             BACKGROUND_ACTIVE,
    output logic             WAKE_FROM_WAIT,
    output logic             COMM_CLOCK_SELECT
);
    // ------------------------------------------------------------
    // interface summary
    // ------------------------------------------------------------
    // a command lives for one strobe cycle and is taken at the rising edge
    // reads answer one cycle later with a one-cycle valid pulse
    // writes give no answer; their effect shows from the next cycle on
    // back-to-back commands are fine; there is no busy state
    // in wait or stop only the status read and background get through
    // a refused command answers with a one-cycle refusal pulse instead
    // cpu flags arrive already in this clock domain, so nothing is resynced
    // entry and break outputs are combinational so that the cpu can act
    // on them in the cycle of the request, at the price of a longer path
    // after reset: all fields zero, user mode, alternate link clock and
    // breakpoint off; the first command may come at the first edge
    // status byte, bit 7 down to 0: permit, active, break enable,
    // force/tag select, clock select, wait/stop, wait/stop failure,
    // data valid failure

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // control fields, status flags, breakpoint word and run state
    logic                  background_permit;
    logic                  hw_break_enable;
    logic                  force_tag_select;
    logic                  comm_clock_select;
    logic                  wait_stop_status;
    logic                  wait_stop_failure;
    logic [15:0]           debug_break_match;
    bdc_pkg::run_type      run_state;
    bdc_pkg::run_type      next_run_state;
    // remembers last cycle's memory command for the collision window
    logic                  mem_in_flight;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // one place for the opcode compare, used by every decode below
    function automatic logic is_cmd(input logic [2:0] c, input logic [2:0] code);
        is_cmd = (c == code);
    endfunction

    // wait or stop lets only the status read and background through
    wire cmd_ok        = CMD_STROBE && !(run_state == bdc_pkg::RUN_WAIT &&
                         !is_cmd(CMD, bdc_pkg::CMD_BACKGROUND) &&
                         !is_cmd(CMD, bdc_pkg::CMD_READ_STAT));
    // one enable per command, all gated by the wait filter
    wire wr_ctrl       = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_WRITE_CTRL);
    wire wr_brk        = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_WRITE_BRK);
    wire rd_stat       = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_READ_STAT);
    wire rd_brk        = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_READ_BRK);
    wire bgnd_cmd      = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_BACKGROUND);
    wire mem_cmd       = cmd_ok && is_cmd(CMD, bdc_pkg::CMD_MEMORY);
    wire is_active     = (run_state == bdc_pkg::RUN_ACTIVE);
    wire is_waiting    = (run_state == bdc_pkg::RUN_WAIT);
    // a strobe that the wait filter blocked; answered, never acted on
    wire refuse        = CMD_STROBE && !cmd_ok;

    // ------------------------------------------------------------
    // breakpoint comparator
    // ------------------------------------------------------------
    // with the enable low the comparator neither tags an opcode nor
    // raises a force request, so the select bit and match word are ignored
    // a flushed queue end drops its tag: that opcode never executes
    // force requests wait in the comparator for the next boundary
    // the tag output goes to the opcode queue beside the fetched byte
    logic brk_force;
    logic brk_tag;

    break_match u_match (
        .clk           (MCLK),
        .rst_n         (RST_N),
        .enable        (hw_break_enable),
        .force_sel     (force_tag_select),
        .match_addr    (debug_break_match),
        .cpu_addr      (CPU_ADDR),
        .cpu_fetch     (CPU_FETCH),
        .cpu_boundary  (CPU_BOUNDARY),
        .cpu_queue_end (CPU_QUEUE_END),
        .cpu_tag_out   (CPU_TAG_OUT),
        .cpu_flush     (CPU_FLUSH),
        .force_req     (brk_force),
        .tag_in        (TAG_IN),
        .tag_hit       (brk_tag)
    );

    // ------------------------------------------------------------
    // background entry
    // ------------------------------------------------------------
    // any break source; without permit the cpu takes a software interrupt instead
    // a tag or force hit, or a background opcode; none counts while active
    // the cpu sees entry or the interrupt fallback in the same cycle
    wire break_req  = is_active ? 1'b0 :
                      (brk_force || brk_tag || (CPU_BGND_OP && !is_waiting));
    // hazard: a background command and a break in the same cycle both
    // ask for entry; they merge into a single entry pulse
    wire want_enter = break_req || (bgnd_cmd && !is_active);
    wire enter_ok   = want_enter && background_permit;
    assign ENTER_BACKGROUND = enter_ok;
    assign SWI_INSTEAD      = break_req && !background_permit;
    // wake only matters in wait; the cpu leaves wait or stop on it
    assign WAKE_FROM_WAIT   = enter_ok && is_waiting;

    // run state sequencing
    // wait leaves by background entry or resume; active leaves only by
    // resume, so a second break while active is simply not seen
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            bdc_pkg::RUN_USER: begin
                if (enter_ok) begin
                    next_run_state = bdc_pkg::RUN_ACTIVE;
                end else if (CPU_WAIT_STOP_ENTER) begin
                    next_run_state = bdc_pkg::RUN_WAIT;
                end
            end
            bdc_pkg::RUN_WAIT: begin
                if (enter_ok) begin
                    next_run_state = bdc_pkg::RUN_ACTIVE;
                end else if (CPU_RESUME) begin
                    next_run_state = bdc_pkg::RUN_USER;
                end
            end
            bdc_pkg::RUN_ACTIVE: begin
                if (CPU_RESUME) begin
                    next_run_state = bdc_pkg::RUN_USER;
                end
            end
            // a corrupt state code falls back to user mode
            default: next_run_state = bdc_pkg::RUN_USER;
        endcase
    end

    // state register; reset always lands in user mode
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            run_state <= bdc_pkg::RUN_USER;
        end else begin
            run_state <= next_run_state;
        end
    end

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    // only the serial write command reaches these; no memory path exists
    // permit is frozen while background is active, so it can never forbid
    // the very mode that is already in effect
    wire wr_permit = wr_ctrl && !is_active;

    // permit: once set it holds until a reset or a write of zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            background_permit <= bdc_pkg::CTRL_RESET[bdc_pkg::BIT_PERMIT];
        end else if (wr_permit) begin
            background_permit <= CMD_DATA[bdc_pkg::BIT_PERMIT];
        end
    end

    // breakpoint and clock settings: writable in user and active states, not in wait
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hw_break_enable   <= bdc_pkg::CTRL_RESET[bdc_pkg::BIT_BRK_EN];
            force_tag_select  <= bdc_pkg::CTRL_RESET[bdc_pkg::BIT_FORCE_TAG];
            comm_clock_select <= bdc_pkg::CTRL_RESET[bdc_pkg::BIT_CLK_SEL];
        end else if (wr_ctrl) begin
            hw_break_enable   <= CMD_DATA[bdc_pkg::BIT_BRK_EN];
            force_tag_select  <= CMD_DATA[bdc_pkg::BIT_FORCE_TAG];
            comm_clock_select <= CMD_DATA[bdc_pkg::BIT_CLK_SEL];
        end
    end

    // breakpoint register, written only by its own serial command
    // sixteen bits written whole; there is no byte-wise write
    // the enable resets low, so the reset value raises no hit until the enable is written high
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            debug_break_match <= bdc_pkg::MATCH_RESET;
        end else if (wr_brk) begin
            debug_break_match <= CMD_DATA;
        end
    end

    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    // wait/stop flag: set by wait entry, kept when background woke from wait
    // it follows the next state, so it reads 1 from the cycle after entry
    wire next_ws = (next_run_state == bdc_pkg::RUN_WAIT) ||
                   (wait_stop_status && next_run_state == bdc_pkg::RUN_ACTIVE);

    // a memory command in flight collides with a wait entry in the same or next cycle
    // the one-cycle window covers a wait that lands just after the command
    // a hit only marks the failure; aborting the access is the cpu's job
    wire collide = CPU_WAIT_STOP_ENTER && (mem_cmd || mem_in_flight);

    // status flags; the failure flag clears on the next memory command
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_stop_status  <= 1'b0;
            wait_stop_failure <= 1'b0;
            mem_in_flight     <= 1'b0;
        end else begin
            wait_stop_status  <= next_ws;
            mem_in_flight     <= mem_cmd;
            // set wins over the clear done by a fresh memory command
            if (collide) begin
                wait_stop_failure <= 1'b1;
            end else if (mem_cmd) begin
                wait_stop_failure <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    // status byte placed field by field; the four status bits have no
    // write path at all, so a control write can never reach them
    wire [7:0] status_word;
    assign status_word[bdc_pkg::BIT_PERMIT]    = background_permit;
    assign status_word[bdc_pkg::BIT_ACTIVE]    = is_active;
    assign status_word[bdc_pkg::BIT_BRK_EN]    = hw_break_enable;
    assign status_word[bdc_pkg::BIT_FORCE_TAG] = force_tag_select;
    assign status_word[bdc_pkg::BIT_CLK_SEL]   = comm_clock_select;
    assign status_word[bdc_pkg::BIT_WAIT_STOP] = wait_stop_status;
    assign status_word[bdc_pkg::BIT_WS_FAIL]   = wait_stop_failure;
    // no slow memory here, so the data valid failure bit is tied low
    assign status_word[bdc_pkg::BIT_DV_FAIL]   = 1'b0;

    // answers: valid and refusal stand one cycle, the data until the next read
    // the data register keeps its value so a slow host may fetch it late
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RESP_DATA   <= 16'h0000;
            RESP_VALID  <= 1'b0;
            CMD_REFUSED <= 1'b0;
        end else begin
            RESP_VALID  <= rd_stat || rd_brk;
            CMD_REFUSED <= refuse;
            if (rd_stat) begin
                RESP_DATA <= {8'h00, status_word};
            end else if (rd_brk) begin
                RESP_DATA <= debug_break_match;
            end
        end
    end

    // ------------------------------------------------------------
    // level outputs
    // ------------------------------------------------------------
    // the clock select only steers the link clock mux outside this block;
    // changing it in mid-command is left to the host, nothing guards it
    // the active level comes straight from the state register, glitch free
    // limitation: one breakpoint word only; a second hit while a force
    // request waits for its boundary simply merges with the first
    assign BACKGROUND_ACTIVE = is_active;
    assign COMM_CLOCK_SELECT = comm_clock_select;
endmodule

// ---- hdl/break_match.sv ----
// breakpoint address comparator with tag tracking
`timescale 1ns/1ps
module break_match (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        force_sel,
    input  wire logic [15:0] match_addr,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_fetch,
    input  wire logic        cpu_boundary,
    input  wire logic        cpu_queue_end,
    input  wire logic        cpu_tag_out,
    input  wire logic        cpu_flush,
    output logic             force_req,
    output logic             tag_in,
    output logic             tag_hit
);
    wire hit = enable && (cpu_addr == match_addr);
    logic pending;

    // force request held until the next instruction boundary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (!enable || !force_sel || cpu_boundary) begin
            pending <= 1'b0;
        end else if (hit) begin
            pending <= 1'b1;
        end
    end

    assign force_req = enable && force_sel && cpu_boundary && (pending || hit);
    // tag travels with the opcode; the queue reports it back at its end
    assign tag_in  = hit && !force_sel && cpu_fetch;
    assign tag_hit = enable && !force_sel && cpu_queue_end && cpu_tag_out && !cpu_flush;
endmodule
